/* core/pfcpwm_pkg.sv */
// constants and types shared by the pfc pwm and protection logic
// assumes a 25 MHz core clock and comparator flags from the analog front end
//
// How it works
// [R1] peak event when current sense rises to the peak limit, every cycle
// [R2] peak comparator accepted only after holding for the deglitch time
// [R3] output sense below open-loop level flags fault, stops most blocks
// [R4] output sense above soft overvoltage threshold cuts duty at once
// [R5] output sense above hard overvoltage threshold forces drive low at once
// [R6] switching cycles come from an internal fixed-frequency oscillator
// [R7] standby clamps the current-loop output node high
// [R8] each cycle starts with drive off and ramp discharged for min off time
// [R9] after min off, ramp rises; ramp comparator crossing turns drive on
// [R10] on-time fraction limited to the duty ceiling
// [R11] qualified peak event turns drive off and latches off for the cycle
// [R12] min off pulse clears peak and drive latches with top priority
// [R13] output outside window acts on gain path, bypassing voltage loop
// [R14] drive active high, held low during supply undervoltage lockout
// [R15] lockout, brown-out or open loop raise fault and enter standby
// [R16] start driving only when supply, output and input senses are good
// [R17] flags sampled on own clock; intervals are cycle counters
// [R18] hard overvoltage or open loop block drive until cleared at cycle start
package pfcpwm_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int SW_HZ = 65000;
  localparam int DEGLITCH_NS = 300;
  localparam int OFFMIN_NS = 400;
  localparam int DUTY_PCT = 95;
  localparam int PERIOD_CYC = CLK_HZ / SW_HZ;
  localparam int DEGLITCH_CYC =
    (DEGLITCH_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int OFFMIN_CYC = (OFFMIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int MAXON_CYC = (PERIOD_CYC * DUTY_PCT) / 100;
  localparam int CNT_W = 9;
  localparam int DG_W = 4;
  localparam int SYNC_W = 3;
  // soft overvoltage trims the allowed on time by this many cycles
  localparam int SOFT_TRIM_CYC = PERIOD_CYC / 4;

  typedef enum logic [1:0] {
    PFCPWM_STANDBY = 2'b00,
    PFCPWM_OFFMIN = 2'b01,
    PFCPWM_RAMP = 2'b11,
    PFCPWM_ON = 2'b10
  } pfcpwm_state_t;

  function automatic logic [CNT_W-1:0] pfcpwm_cyc(input int n);
    pfcpwm_cyc = n[CNT_W-1:0];
  endfunction : pfcpwm_cyc
endpackage : pfcpwm_pkg

/* core/pfcpwm_sync.sv */
// three-stage synchroniser for one asynchronous comparator flag
// assumes the flag is a level from an analog comparator
`timescale 1ns/1ns
module pfcpwm_sync (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // change counts once second and third stages agree
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dout <= 1'b0;
    end else if (s2 == s3) begin
      dout <= s3;
    end
  end
endmodule : pfcpwm_sync

/* core/pfcpwm_deglitch.sv */
// keeps a flag only after it holds high for a set number of cycles
// assumes a synchronised input on the same clock
`timescale 1ns/1ns
module pfcpwm_deglitch
  import pfcpwm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic din,
  output logic dout
);
  localparam logic [DG_W-1:0] DG_MAX = DG_W'(DEGLITCH_CYC);
  logic [DG_W-1:0] count;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      dout <= 1'b0;
    end else if (!din) begin
      count <= '0;
      dout <= 1'b0;
    end else if (count >= DG_MAX - 1'b1) begin
      dout <= 1'b1; // R2
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule : pfcpwm_deglitch

/* core/pfcpwm_logic.sv */
// pwm sequencing and protection priority for a boost pfc controller
// assumes comparator flags from the analog front end, asynchronous to clock
`timescale 1ns/1ns
module pfcpwm_logic
  import pfcpwm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic supplyUndervoltageLockout,
  input wire logic supplyTurnOnGood,
  input wire logic inputBrownoutGuard,
  input wire logic inputVoltageTurnOnGood,
  input wire logic openLoopComparator,
  input wire logic peakComparator,
  input wire logic rampComparator,
  input wire logic softOvervoltage,
  input wire logic hardOvervoltage,
  input wire logic windowHigh,
  input wire logic windowLow,
  output logic switchDrive,
  output logic rampDischarge,
  output logic currentLoopClamp,
  output logic voltageLoopReset,
  output logic standby,
  output logic openLoopFault,
  output logic peakLimitEvent,
  output logic overvoltageGuard,
  output logic gainBoost,
  output logic gainCut,
  output logic cycleStart
);
  localparam logic [CNT_W-1:0] PERIOD_LAST = pfcpwm_cyc(PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] OFFMIN_LAST = pfcpwm_cyc(OFFMIN_CYC - 1);
  localparam logic [CNT_W-1:0] MAXON = pfcpwm_cyc(MAXON_CYC);
  localparam logic [CNT_W-1:0] SOFT_LIMIT =
    pfcpwm_cyc(MAXON_CYC - SOFT_TRIM_CYC);

  logic uvloSync;
  logic supplyOkSync;
  logic brownSync;
  logic vinOkSync;
  logic olSync;
  logic peakSync;
  logic rampSync;
  logic softSync;
  logic hardSync;
  logic winHiSync;
  logic winLoSync;
  logic peakQual;

  pfcpwm_sync uSyncUvlo (
    .clock(clock),
    .rst_b(rst_b),
    .din(supplyUndervoltageLockout),
    .dout(uvloSync)
  );
  pfcpwm_sync uSyncSupOk (
    .clock(clock),
    .rst_b(rst_b),
    .din(supplyTurnOnGood),
    .dout(supplyOkSync)
  );
  pfcpwm_sync uSyncBrown (
    .clock(clock),
    .rst_b(rst_b),
    .din(inputBrownoutGuard),
    .dout(brownSync)
  );
  pfcpwm_sync uSyncVinOk (
    .clock(clock),
    .rst_b(rst_b),
    .din(inputVoltageTurnOnGood),
    .dout(vinOkSync)
  );
  pfcpwm_sync uSyncOl (
    .clock(clock),
    .rst_b(rst_b),
    .din(openLoopComparator), // R17
    .dout(olSync)
  );
  pfcpwm_sync uSyncPeak (
    .clock(clock),
    .rst_b(rst_b),
    .din(peakComparator),
    .dout(peakSync)
  );
  pfcpwm_sync uSyncRamp (
    .clock(clock),
    .rst_b(rst_b),
    .din(rampComparator),
    .dout(rampSync)
  );
  pfcpwm_sync uSyncSoft (
    .clock(clock),
    .rst_b(rst_b),
    .din(softOvervoltage),
    .dout(softSync)
  );
  pfcpwm_sync uSyncHard (
    .clock(clock),
    .rst_b(rst_b),
    .din(hardOvervoltage),
    .dout(hardSync)
  );
  pfcpwm_sync uSyncWinHi (
    .clock(clock),
    .rst_b(rst_b),
    .din(windowHigh),
    .dout(winHiSync)
  );
  pfcpwm_sync uSyncWinLo (
    .clock(clock),
    .rst_b(rst_b),
    .din(windowLow),
    .dout(winLoSync)
  );

  // peak comparator asserts when current sense reaches the limit
  pfcpwm_deglitch uDeglitch (.clock(clock), .rst_b(rst_b),
    .din(peakSync), .dout(peakQual)); // R1

  // fault and standby qualification
  logic fault;
  logic startOk;
  logic running;
  assign fault = uvloSync | brownSync | olSync; // R15
  assign startOk = supplyOkSync & !olSync & vinOkSync; // R16

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      running <= 1'b0;
    end else if (fault) begin
      running <= 1'b0; // R15
    end else if (startOk) begin
      running <= 1'b1; // R16
    end
  end

  // free-running oscillator period counter
  logic [CNT_W-1:0] phase;
  logic periodEnd;
  assign periodEnd = (phase == PERIOD_LAST);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase <= '0;
    end else if (periodEnd) begin
      phase <= '0; // R6
    end else begin
      phase <= phase + 1'b1;
    end
  end

  // cycle state machine
  pfcpwm_state_t state;
  pfcpwm_state_t next_state;
  logic offminPulse;
  logic [CNT_W-1:0] onLimit;
  assign offminPulse = (state == PFCPWM_OFFMIN);
  assign onLimit = softSync ? SOFT_LIMIT : MAXON; // R4

  // hard overvoltage and open loop hold off the drive for the cycle
  logic blockLatch;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      blockLatch <= 1'b1;
    end else if (periodEnd) begin
      blockLatch <= hardSync | olSync; // R18
    end else if (hardSync | olSync) begin
      blockLatch <= 1'b1; // R18
    end
  end

  // peak current latch, cleared only by the min off pulse
  logic peakLatch;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      peakLatch <= 1'b0;
    end else if (offminPulse) begin
      peakLatch <= 1'b0; // R12
    end else if (peakQual) begin
      peakLatch <= 1'b1; // R11
    end
  end

  logic killNow;
  assign killNow = !running | hardSync | olSync | blockLatch | peakQual
    | peakLatch; // R5

  always_comb begin
    next_state = state;
    case (state)
      PFCPWM_STANDBY: begin
        if (running && periodEnd) begin
          next_state = PFCPWM_OFFMIN;
        end
      end
      PFCPWM_OFFMIN: begin
        if (!running) begin
          next_state = PFCPWM_STANDBY;
        end else if (phase == OFFMIN_LAST) begin
          next_state = PFCPWM_RAMP; // R9
        end
      end
      PFCPWM_RAMP: begin
        if (!running) begin
          next_state = PFCPWM_STANDBY;
        end else if (periodEnd) begin
          next_state = PFCPWM_OFFMIN; // R8
        end else if (rampSync && !killNow && phase < onLimit) begin
          next_state = PFCPWM_ON; // R9
        end
      end
      PFCPWM_ON: begin
        if (!running) begin
          next_state = PFCPWM_STANDBY;
        end else if (periodEnd) begin
          next_state = PFCPWM_OFFMIN; // R8
        end
      end
      default: begin
        next_state = PFCPWM_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= PFCPWM_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  // drive output: off during min off, on after crossing, killed by faults
  logic next_drive;
  always_comb begin
    next_drive = 1'b0;
    if (next_state == PFCPWM_ON && !killNow && !offminPulse) begin
      next_drive = (phase < onLimit); // R10
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      switchDrive <= 1'b0; // R14
    end else if (uvloSync) begin
      switchDrive <= 1'b0; // R14
    end else if (next_state == PFCPWM_OFFMIN) begin
      switchDrive <= 1'b0; // R8
    end else if (peakQual | hardSync) begin
      switchDrive <= 1'b0; // R11
    end else begin
      switchDrive <= next_drive;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rampDischarge <= 1'b1;
    end else begin
      rampDischarge <= (next_state != PFCPWM_RAMP)
        && (next_state != PFCPWM_ON); // R8
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cycleStart <= 1'b0;
    end else begin
      cycleStart <= running & periodEnd;
    end
  end

  // status and analog-control outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      standby <= 1'b1;
      currentLoopClamp <= 1'b1;
      voltageLoopReset <= 1'b1;
    end else begin
      standby <= !running;
      currentLoopClamp <= !running; // R7
      voltageLoopReset <= fault; // R3
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      openLoopFault <= 1'b0;
      peakLimitEvent <= 1'b0;
      overvoltageGuard <= 1'b0;
    end else begin
      openLoopFault <= olSync; // R3
      peakLimitEvent <= peakQual; // R1
      overvoltageGuard <= softSync | hardSync; // R4
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gainBoost <= 1'b0;
      gainCut <= 1'b0;
    end else begin
      gainBoost <= running & winLoSync; // R13
      gainCut <= running & winHiSync; // R13
    end
  end
endmodule : pfcpwm_logic

/* verif/pfcpwm_logic_properties.sv */
// assertions on the ports of the pfc pwm logic
// assumes a bind into pfcpwm_logic and the package constants
`timescale 1ns/1ns
module pfcpwm_logic_checker
  import pfcpwm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic peakComparator,
  input wire logic hardOvervoltage,
  input wire logic switchDrive,
  input wire logic rampDischarge,
  input wire logic standby,
  input wire logic openLoopFault,
  input wire logic peakLimitEvent,
  input wire logic overvoltageGuard,
  input wire logic cycleStart
);
  logic [9:0] onCount;
  logic [9:0] phase;
  logic peakSeen;
  logic csSeen;
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // pulse length, period phase, peak memory within a period
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      onCount <= 10'h000;
      phase <= 10'h000;
      peakSeen <= 1'b0;
      csSeen <= 1'b0;
    end else begin
      onCount <= switchDrive ? onCount + 10'h001 : 10'h000;
      phase <= (cycleStart || standby) ? 10'h000 : phase + 10'h001;
      peakSeen <= !cycleStart && (peakSeen || peakLimitEvent);
      csSeen <= !standby && (csSeen || cycleStart);
    end
  end
  sequence offHeld;
    (rampDischarge && !switchDrive) [*8];
  endsequence
  a_offmin_held: assert property (cycleStart |=> offHeld)
    else $error("drive or ramp active in min off");
  a_ramp_first: assert property ($rose(switchDrive) |-> !rampDischarge)
    else $error("drive rose with ramp held");
  a_standby_low: assert property (standby |-> !switchDrive)
    else $error("drive high in standby");
  a_peak_latch: assert property (
    peakSeen && $past(peakSeen) |-> !switchDrive)
    else $error("drive on after peak event");
  a_peak_deglitch: assert property (
    $rose(peakLimitEvent) |-> $past(peakComparator, 8)
      && $past(peakComparator, 10))
    else $error("peak event without held flag");
  a_duty_ceiling: assert property (int'(onCount) <= MAXON_CYC)
    else $error("on time above ceiling");
  a_soft_trim: assert property (
    overvoltageGuard && $past(overvoltageGuard, 3)
      |-> int'(onCount) <= MAXON_CYC - SOFT_TRIM_CYC)
    else $error("on time not trimmed");
  a_hard_off: assert property (hardOvervoltage [*8] |-> !switchDrive)
    else $error("drive on in hard overvoltage");
  a_open_standby: assert property (openLoopFault [*2] |-> standby)
    else $error("open loop without standby");
  a_period_fixed: assert property (
    cycleStart && csSeen |-> int'(phase) == PERIOD_CYC - 1)
    else $error("switching period wrong");
endmodule : pfcpwm_logic_checker

bind pfcpwm_logic pfcpwm_logic_checker i_chk (
  .clock, .rst_b, .peakComparator, .hardOvervoltage, .switchDrive,
  .rampDischarge, .standby, .openLoopFault, .peakLimitEvent,
  .overvoltageGuard, .cycleStart
);

/* verif/pfcpwm_analog.sv */
// ramp and inductor current model facing the pwm logic
// assumes drive and ramp discharge on the same clock
`timescale 1ns/1ns
module pfcpwm_analog (
  input wire logic clock,
  input wire logic switchDrive,
  input wire logic rampDischarge,
  input wire logic [8:0] rampLevel,
  input wire logic [8:0] peakLevel,
  input wire logic glitch,
  output logic rampComparator,
  output logic peakComparator
);
  logic [8:0] ramp;
  logic [8:0] current;
  always_ff @(posedge clock) begin
    ramp <= rampDischarge ? 9'h000 : ramp + 9'h001;
    rampComparator <= !rampDischarge && ramp >= rampLevel;
  end
  // current rises only while the switch conducts
  always_ff @(posedge clock) begin
    current <= switchDrive ? current + 9'h001 : 9'h000;
    peakComparator <= glitch || current >= peakLevel;
  end
endmodule : pfcpwm_analog

/* verif/pfcpwm_logic_tb.sv */
// self-checking bench for the pfc pwm and protection logic
// assumes pfcpwm_analog for the switch and comparators
`timescale 1ns/1ns
module pfcpwm_logic_tb
  import pfcpwm_pkg::*;
;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic supplyUndervoltageLockout = 1'b1;
  logic supplyTurnOnGood = 1'b0;
  logic inputBrownoutGuard = 1'b0;
  logic inputVoltageTurnOnGood = 1'b0;
  logic openLoopComparator = 1'b0;
  logic softOvervoltage = 1'b0;
  logic hardOvervoltage = 1'b0;
  logic windowHigh = 1'b0;
  logic windowLow = 1'b0;
  logic glitch = 1'b0;
  logic [8:0] rampLevel = 9'h064;
  logic [8:0] peakLevel = 9'h1FF;
  logic peakComparator, rampComparator, switchDrive, rampDischarge;
  logic currentLoopClamp, voltageLoopReset, standby, openLoopFault;
  logic peakLimitEvent, overvoltageGuard, gainBoost, gainCut, cycleStart;
  int mismatches = 0;
  int comparisons = 0;
  int maxOn, rises;
  logic peakSeen;
  always #20 clock = ~clock;
  pfcpwm_logic i_dut (.*);
  pfcpwm_analog i_far (.*);
  task automatic check(input string name, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check
  // longest pulse and rising edges over n cycles, sampled mid-cycle
  task automatic span(input int n);
    int len;
    logic prev;
    len = 0;
    prev = 1'b1;
    maxOn = 0;
    rises = 0;
    peakSeen = 1'b0;
    repeat (n) begin
      @(negedge clock);
      len = (switchDrive === 1'b1) ? len + 1 : 0;
      if (switchDrive === 1'b1 && prev === 1'b0) rises++;
      prev = switchDrive;
      if (len > maxOn) maxOn = len;
      if (peakLimitEvent === 1'b1) peakSeen = 1'b1;
    end
  endtask : span
  function automatic logic inr(input int hi);
    return maxOn <= hi && maxOn >= hi - 12;
  endfunction : inr
  // start the next span at a period start
  task automatic align();
    @(posedge clock);
    wait (cycleStart === 1'b1);
  endtask : align
  task automatic end_of_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic t_start();
    span(2);
    check("standby", 1'b1, standby);
    check("clamp", 1'b1, currentLoopClamp);
    check("drive", 1'b0, switchDrive);
    @(posedge clock);
    supplyUndervoltageLockout <= 1'b0;
    supplyTurnOnGood <= 1'b1;
    span(20);
    check("early", 1'b1, standby);
    @(posedge clock);
    inputVoltageTurnOnGood <= 1'b1;
    span(20);
    check("run", 1'b0, standby);
    check("unclamp", 1'b0, currentLoopClamp);
    check("vloop", 1'b0, voltageLoopReset);
  endtask : t_start
  task automatic t_pwm();
    align();
    span(2 * PERIOD_CYC + 1);
    check("ramp", 1'b1, inr(MAXON_CYC - OFFMIN_CYC - 100));
    check("pulses", 2, rises);
    @(posedge clock);
    rampLevel <= 9'h000;
    span(PERIOD_CYC);
    span(2 * PERIOD_CYC + 1);
    check("ceiling", 1'b1, inr(MAXON_CYC - OFFMIN_CYC));
  endtask : t_pwm
  task automatic t_peak();
    @(posedge clock);
    peakLevel <= 9'h032;
    align();
    span(2 * PERIOD_CYC + 1);
    check("peak", 1'b1, inr(50 + DEGLITCH_CYC + 12));
    check("event", 1'b1, peakSeen);
    check("restart", 2, rises);
    @(posedge clock);
    peakLevel <= 9'h1FF;
    span(20);
    @(posedge clock);
    glitch <= 1'b1;
    span(DEGLITCH_CYC - 3);
    @(posedge clock);
    glitch <= 1'b0;
    span(30);
    check("glitch", 1'b0, peakSeen);
  endtask : t_peak
  task automatic t_ov();
    @(posedge clock);
    softOvervoltage <= 1'b1;
    span(PERIOD_CYC);
    check("guard", 1'b1, overvoltageGuard);
    span(2 * PERIOD_CYC + 1);
    check("soft", 1'b1, inr(MAXON_CYC - SOFT_TRIM_CYC - OFFMIN_CYC));
    @(posedge clock);
    softOvervoltage <= 1'b0;
    hardOvervoltage <= 1'b1;
    span(20);
    span(2 * PERIOD_CYC + 1);
    check("hard", 0, maxOn);
    @(posedge clock);
    hardOvervoltage <= 1'b0;
  endtask : t_ov
  task automatic t_fault();
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      supplyUndervoltageLockout <= (i == 0);
      inputBrownoutGuard <= (i == 1);
      openLoopComparator <= (i == 2);
      span(10);
      check("fault", 1'b1, standby && voltageLoopReset);
      check("off", 1'b0, switchDrive);
      check("open", i == 2, openLoopFault);
    end
    @(posedge clock);
    openLoopComparator <= 1'b0;
    windowLow <= 1'b1;
    span(30);
    check("boost", 2'b10, {gainBoost, gainCut});
    @(posedge clock);
    windowLow <= 1'b0;
    windowHigh <= 1'b1;
    span(10);
    check("cut", 2'b01, {gainBoost, gainCut});
  endtask : t_fault
  initial begin
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    t_start();
    t_pwm();
    t_peak();
    t_ov();
    t_fault();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    end_of_test();
  end
endmodule : pfcpwm_logic_tb
